// ---- rtl/fpwp_pkg.sv ----
// Package: constants and types for the flash partition and write-protect configuration block
package fpwp_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W = 14;
  localparam logic [13:0] CFG_BLANK = 14'h3fff;
  localparam logic [13:0] CFG_UNIMPL_MASK = 14'h1460;
  localparam logic [13:0] CFG_STICKY_MASK = 14'h0b98;
  localparam logic [13:0] CFG_SIZE_MASK = 14'h0007;
  localparam int LVP_BIT = 13;
  localparam int SAF_WP_BIT = 11;
  localparam int CFG_WP_BIT = 9;
  localparam int BOOT_WP_BIT = 8;
  localparam int APP_WP_BIT = 7;
  localparam int SAF_EN_BIT = 4;
  localparam int BOOT_EN_BIT = 3;

  // ----------------------------------------------------------------
  // Boot region sizing
  // ----------------------------------------------------------------
  localparam logic [16:0] BOOT_MIN_WORDS = 17'h00200;
  localparam logic [2:0] BOOT_SEL_MAX = 3'h7;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam int CTRL_ERASE_BIT = 0;
  localparam int CTRL_RSTEN_BIT = 1;
  localparam int STAT_HV_BIT = 0;
  localparam int STAT_LV_BIT = 1;
  localparam int STAT_LVEN_BIT = 2;
  localparam int STAT_RST_BIT = 3;
  localparam int STAT_SIZE_LSB = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [13:0] cfg;
    logic ext_reset_pin_enable;
    logic hv_s1;
    logic hv_s2;
    logic lv_s1;
    logic lv_s2;
    logic [31:0] rd_data;
    logic slverr;
    logic sw_done;
    logic sw_blocked;
  } fpwp_state_t;

  typedef struct packed {
    logic boot;
    logic storage_area_flash;
    logic app;
    logic cfg;
  } fpwp_hits_t;

endpackage

// ---- rtl/fpwp_region_hit.sv ----
// Address window comparator for one flash region
`timescale 1ns/1ps
module fpwp_region_hit
  import fpwp_pkg::*;
#(
  parameter int AW = 16
)
(
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] first,
  input wire logic [AW-1:0] last,
  input wire logic enable,
  output logic hit
);

  // ----------------------------------------------------------------
  // Inclusive window test
  // ----------------------------------------------------------------
  assign hit = enable && (addr >= first) && (addr <= last);

endmodule

// ---- rtl/fpwp_top.sv ----
// Flash partition and write-protect configuration block with APB register access
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
//
// Contract
// - Low-voltage enable set makes shared pin a reset; external reset enable ignored.
// - Low-voltage enable clear allows programming entry only with high voltage present.
// - Clearing low-voltage enable is refused while in low-voltage programming.
// - Storage area write protect low guards storage area, only when it is enabled.
// - Config area write protect low guards the configuration words against writes.
// - Boot write protect low guards boot region, only when boot region enabled.
// - Application write protect low guards the application region against writes.
// - Storage area enable is active low; zero creates the storage partition.
// - Boot region enable is active low; zero creates the boot partition.
// - Boot size select applies only when enabled; otherwise size is zero.
// - Boot size select is writable only while the boot region is disabled.
// - Selects 111,110,101,100 give 512,1024,2048,4096 words from address zero.
// - Boot region is clamped to half the program memory size.
// - Protection and partition bits are sticky; only bulk erase releases them.
// - Unimplemented bits 12, 10, 6 and 5 always read as one.
// - Blank or bulk-erased word reads all ones: everything unprotected, low-voltage on.
// - Protection blocks self-writes; config protect also refuses APB config writes outside programming mode, so a boot loader survives updates.
module fpwp_top
  import fpwp_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int PROG_WORDS = 8192,
  parameter int SAF_WORDS = 128,
  parameter logic [15:0] CFG_FIRST = 16'h8007,
  parameter logic [15:0] CFG_LAST = 16'h800b
)
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HV_DETECT,
  input wire logic LVP_ENTRY,
  input wire logic SW_REQ,
  input wire logic [ADDR_W-1:0] SW_ADDR,
  output logic SW_DONE,
  output logic SW_BLOCKED,
  output logic PROG_MODE,
  output logic LV_PROG_ENABLE,
  output logic EXT_RESET_ACTIVE,
  output logic [13:0] CFG_WORD
);

  fpwp_state_t st;
  fpwp_state_t next_st;
  fpwp_hits_t hits;
  logic hv_mode;
  logic lv_mode;
  logic prog_mode;
  logic boot_on;
  logic saf_on;
  logic [16:0] boot_raw;
  logic [16:0] boot_half;
  logic [16:0] boot_words;
  logic [ADDR_W-1:0] boot_last;
  logic [ADDR_W-1:0] saf_first;
  logic [ADDR_W-1:0] app_last;
  logic [ADDR_W-1:0] mem_last;
  logic sw_block_now;
  logic setup;
  logic access;
  logic cfg_ok;
  logic erase_go;
  logic cfg_wr;
  logic [13:0] wr_word;

  // ----------------------------------------------------------------
  // Programming mode
  // ----------------------------------------------------------------
  // high voltage entry
  assign hv_mode = st.hv_s2;
  assign lv_mode = st.lv_s2 && st.cfg[LVP_BIT];
  assign prog_mode = hv_mode || lv_mode;

  // ----------------------------------------------------------------
  // Partition geometry
  // ----------------------------------------------------------------
  // boot partition enable
  assign boot_on = !st.cfg[BOOT_EN_BIT];
  assign saf_on = !st.cfg[SAF_EN_BIT];
  assign boot_raw = BOOT_MIN_WORDS << (BOOT_SEL_MAX - st.cfg[2:0]);
  assign boot_half = 17'(PROG_WORDS / 2);
  assign boot_words = !boot_on ? 17'h00000 : (boot_raw > boot_half) ? boot_half : boot_raw;
  assign boot_last = ADDR_W'(boot_words - 17'h00001);
  assign mem_last = ADDR_W'(PROG_WORDS - 1);
  assign saf_first = ADDR_W'(PROG_WORDS - SAF_WORDS);
  assign app_last = saf_on ? saf_first - ADDR_W'(1) : mem_last;

  fpwp_region_hit #(.AW(ADDR_W)) u_boot_hit (
    .addr(SW_ADDR),
    .first('0),
    .last(boot_last),
    .enable(boot_on),
    .hit(hits.boot)
  );

  fpwp_region_hit #(.AW(ADDR_W)) u_saf_hit (
    .addr(SW_ADDR),
    .first(saf_first),
    .last(mem_last),
    .enable(saf_on),
    .hit(hits.storage_area_flash)
  );

  fpwp_region_hit #(.AW(ADDR_W)) u_app_hit (
    .addr(SW_ADDR),
    .first(ADDR_W'(boot_words)),
    .last(app_last),
    .enable(1'b1),
    .hit(hits.app)
  );

  fpwp_region_hit #(.AW(ADDR_W)) u_cfg_hit (
    .addr(SW_ADDR),
    .first(ADDR_W'(CFG_FIRST)),
    .last(ADDR_W'(CFG_LAST)),
    .enable(1'b1),
    .hit(hits.cfg)
  );

  // ----------------------------------------------------------------
  // Self-write protection check
  // ----------------------------------------------------------------
  // storage area guard
  assign sw_block_now = (hits.storage_area_flash && !st.cfg[SAF_WP_BIT]) || (hits.cfg && !st.cfg[CFG_WP_BIT]) ||
    (hits.boot && !st.cfg[BOOT_WP_BIT]) || (hits.app && !st.cfg[APP_WP_BIT]);

  // ----------------------------------------------------------------
  // APB decode and configuration word update
  // ----------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && !st.slverr;
  // Programmer writes bypass the config guard; software writes do not
  assign cfg_ok = prog_mode || st.cfg[CFG_WP_BIT];
  assign cfg_wr = access && PWRITE && (PADDR == OFF_CONFIG);
  assign erase_go = access && PWRITE && (PADDR == OFF_CONTROL) && PWDATA[CTRL_ERASE_BIT];

  always_comb
  begin
    wr_word = PWDATA[13:0];
    wr_word = (wr_word & ~CFG_STICKY_MASK) | (wr_word & st.cfg & CFG_STICKY_MASK);
    if (!st.cfg[BOOT_EN_BIT])
    begin
      wr_word = (wr_word & ~CFG_SIZE_MASK) | (st.cfg & CFG_SIZE_MASK);
    end
    if (lv_mode)
    begin
      wr_word[LVP_BIT] = 1'b1;
    end
    wr_word = wr_word | CFG_UNIMPL_MASK;
  end

  always_comb
  begin
    next_st = st;
    // Two flops on each pin input; only the second is read
    next_st.hv_s1 = HV_DETECT;
    next_st.hv_s2 = st.hv_s1;
    next_st.lv_s1 = LVP_ENTRY;
    next_st.lv_s2 = st.lv_s1;
    next_st.sw_done = SW_REQ;
    next_st.sw_blocked = SW_REQ && sw_block_now;
    if (setup)
    begin
      next_st.slverr = 1'b0;
      next_st.rd_data = 32'h00000000;
      unique case (PADDR)
        OFF_CONFIG:
        begin
          next_st.rd_data = {18'h00000, st.cfg};
          next_st.slverr = PWRITE && !cfg_ok;
        end
        OFF_CONTROL:
        begin
          next_st.rd_data[CTRL_RSTEN_BIT] = st.ext_reset_pin_enable;
          next_st.slverr = PWRITE && PWDATA[CTRL_ERASE_BIT] && !prog_mode;
        end
        OFF_STATUS:
        begin
          next_st.rd_data[STAT_HV_BIT] = hv_mode;
          next_st.rd_data[STAT_LV_BIT] = lv_mode;
          next_st.rd_data[STAT_LVEN_BIT] = st.cfg[LVP_BIT];
          next_st.rd_data[STAT_RST_BIT] = EXT_RESET_ACTIVE;
          next_st.rd_data[STAT_SIZE_LSB +: 16] = boot_words[15:0];
          next_st.slverr = PWRITE;
        end
        default:
        begin
          next_st.slverr = 1'b1;
        end
      endcase
    end
    if (cfg_wr)
    begin
      next_st.cfg = wr_word;
    end
    if (access && PWRITE && (PADDR == OFF_CONTROL))
    begin
      next_st.ext_reset_pin_enable = PWDATA[CTRL_RSTEN_BIT];
    end
    if (erase_go)
    begin
      next_st.cfg = CFG_BLANK;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset restores the blank word; nonvolatile reload is outside this block
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st <= '{cfg: CFG_BLANK, ext_reset_pin_enable: 1'b1, hv_s1: 1'b0, hv_s2: 1'b0, lv_s1: 1'b0,
        lv_s2: 1'b0, rd_data: 32'h00000000, slverr: 1'b0, sw_done: 1'b0, sw_blocked: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA = st.rd_data;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && st.slverr;
  assign SW_DONE = st.sw_done;
  assign SW_BLOCKED = st.sw_blocked;
  assign PROG_MODE = prog_mode;
  assign LV_PROG_ENABLE = st.cfg[LVP_BIT];
  assign EXT_RESET_ACTIVE = st.cfg[LVP_BIT] || st.ext_reset_pin_enable;
  assign CFG_WORD = st.cfg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  a_lvp_reset_pin: assert property (st.cfg[LVP_BIT] |-> EXT_RESET_ACTIVE)
    else $error("reset pin function not forced while low-voltage enable set");
  a_hv_only_entry: assert property (!st.cfg[LVP_BIT] && !st.hv_s2 |-> !PROG_MODE)
    else $error("programming mode entered without high voltage");
  a_lvp_clear_block: assert property (lv_mode && cfg_wr && !erase_go |=> st.cfg[LVP_BIT])
    else $error("low-voltage enable cleared during low-voltage programming");
  a_saf_guard: assert property (SW_REQ && saf_on && hits.storage_area_flash && !st.cfg[SAF_WP_BIT]
    |=> SW_DONE && SW_BLOCKED)
    else $error("write to protected storage area not suppressed");
  a_cfg_guard: assert property (SW_REQ && hits.cfg && !st.cfg[CFG_WP_BIT] |=> SW_BLOCKED)
    else $error("write to protected config area not suppressed");
  a_boot_guard: assert property (SW_REQ && boot_on && SW_ADDR <= boot_last && !st.cfg[BOOT_WP_BIT]
    |=> SW_BLOCKED)
    else $error("write to protected boot region not suppressed");
  a_app_guard: assert property (SW_REQ && hits.app && !st.cfg[APP_WP_BIT] |=> SW_BLOCKED)
    else $error("write to protected application region not suppressed");
  a_boot_size_zero: assert property (st.cfg[BOOT_EN_BIT] |-> boot_words == 17'h00000)
    else $error("boot size not zero while disabled");
  a_size_locked: assert property (!st.cfg[BOOT_EN_BIT] && !erase_go |=> $stable(st.cfg[2:0]))
    else $error("boot size changed while boot region enabled");
  a_boot_clamp: assert property (boot_words <= boot_half)
    else $error("boot region larger than half memory");
  a_sticky_bits: assert property (!erase_go |=> ((~$past(st.cfg)) & st.cfg & CFG_STICKY_MASK) == 14'h0000)
    else $error("sticky protection released without bulk erase");
  a_unimpl_ones: assert property ((CFG_WORD & CFG_UNIMPL_MASK) == CFG_UNIMPL_MASK)
    else $error("unimplemented bit reads zero");
  a_erase_blank: assert property (erase_go |=> CFG_WORD == CFG_BLANK ##1 LV_PROG_ENABLE)
    else $error("bulk erase did not restore blank word");
  a_unprot_pass: assert property (SW_REQ && !sw_block_now |=> SW_DONE && !SW_BLOCKED)
    else $error("unprotected self-write was suppressed");

  c_blocked_write: cover property (SW_REQ ##1 SW_BLOCKED);
  c_bulk_erase: cover property (erase_go);
  c_boot_enable: cover property (st.cfg[BOOT_EN_BIT] ##1 !st.cfg[BOOT_EN_BIT]);
  c_refused_write: cover property (PSEL && PENABLE && PSLVERR);

endmodule

// ---- test/fpwp_prog_model.sv ----
// Partner model: programmer voltage pins and self-write requester
`timescale 1ns/1ps
module fpwp_prog_model
  import fpwp_pkg::*;
#(
  parameter int AW = 16
)
(
  input wire logic clk,
  input wire logic sw_done,
  input wire logic sw_blocked,
  output logic hv_detect,
  output logic lvp_entry,
  output logic sw_req,
  output logic [AW-1:0] sw_addr
);
  initial
  begin
    hv_detect = 1'b0;
    lvp_entry = 1'b0;
    sw_req = 1'b0;
    sw_addr = '0;
  end

  // ----------------------------------------------------------------
  // Programmer pins
  // ----------------------------------------------------------------
  // programmer drives the high-voltage and low-voltage entry pins
  task automatic set_mode(input logic hv, input logic lv);
    @(posedge clk);
    hv_detect <= hv;
    lvp_entry <= lv;
    // Pins pass a two-flop synchroniser, so allow settling
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Self-write requests
  // ----------------------------------------------------------------
  task automatic self_write(input logic [AW-1:0] a, output logic d, output logic b);
    @(posedge clk);
    sw_req <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_req <= 1'b0;
    // Address is not held once the request is gone
    sw_addr <= ~a;
    @(posedge clk);
    d = sw_done;
    b = sw_blocked;
  endtask
endmodule

// ---- test/tb.sv ----
// Testbench: register and self-write sequences for the partition config block
`timescale 1ns/1ps
module tb;
  import fpwp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hv, lv, sw_req, sw_done, sw_blk, pm, lv_en, ext;
  logic [15:0] sw_addr;
  logic [13:0] cfg;
  int n_mismatch = 0;
  int samples_checked = 0;
  int exp_size;

  always #4 clk = ~clk;

  fpwp_top dut_u (.REF_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HV_DETECT(hv), .LVP_ENTRY(lv), .SW_REQ(sw_req), .SW_ADDR(sw_addr), .SW_DONE(sw_done),
    .SW_BLOCKED(sw_blk), .PROG_MODE(pm), .LV_PROG_ENABLE(lv_en), .EXT_RESET_ACTIVE(ext), .CFG_WORD(cfg));

  fpwp_prog_model prog_u (.clk(clk), .sw_done(sw_done), .sw_blocked(sw_blk), .hv_detect(hv),
    .lvp_entry(lv), .sw_req(sw_req), .sw_addr(sw_addr));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and request tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      cmp("pready", 32'h1, {31'h0, pready});
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // The write landed at the last rising edge, so callers compare outputs only after this falling edge
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp("pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp("prdata", exp, r);
    cmp("pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic sw(input logic [15:0] a, input logic exp_blk);
    logic d;
    logic b;
    prog_u.self_write(a, d, b);
    cmp("sw_done", 32'h1, {31'h0, d});
    cmp("sw_blocked", {31'h0, exp_blk}, {31'h0, b});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_CONFIG, 32'h3fff);
    rd(OFF_STATUS, 32'h0000000c);
    cmp("ext_reset", 32'h1, {31'h0, ext});
    wr(8'h0c, 32'h0, 1'b1);
    wr(OFF_STATUS, 32'h0, 1'b1);
    wr(OFF_CONFIG, 32'h3ef6, 1'b0);
    rd(OFF_STATUS, 32'h0400000c);
    sw(16'h03ff, 1'b1);
    sw(16'h0400, 1'b0);
    // Sticky bits and the locked size field must both survive
    wr(OFF_CONFIG, 32'h3fff, 1'b0);
    rd(OFF_CONFIG, 32'h3ef6);
    wr(OFF_CONFIG, 32'h3e66, 1'b0);
    sw(16'h1f80, 1'b0);
    sw(16'h1f7f, 1'b1);
    wr(OFF_CONFIG, 32'h3666, 1'b0);
    sw(16'h1f80, 1'b1);
    wr(OFF_CONFIG, 32'h3466, 1'b0);
    wr(OFF_CONFIG, 32'h3fff, 1'b1);
    sw(16'h8007, 1'b1);
    sw(16'h8006, 1'b0);
    wr(OFF_CONTROL, 32'h1, 1'b1);
    prog_u.set_mode(1'b1, 1'b0);
    cmp("prog_mode", 32'h1, {31'h0, pm});
    wr(OFF_CONTROL, 32'h3, 1'b0);
    rd(OFF_CONFIG, 32'h3fff);
    for (int s = 0; s < 8; s++)
    begin
      wr(OFF_CONTROL, 32'h3, 1'b0);
      wr(OFF_CONFIG, 32'h3ff0 | s, 1'b0);
      exp_size = 512 << (7 - s);
      if (exp_size > 4096)
        exp_size = 4096;
      rd(OFF_STATUS, {exp_size[15:0], 16'h000d});
    end
    wr(OFF_CONTROL, 32'h3, 1'b0);
    prog_u.set_mode(1'b0, 1'b1);
    cmp("prog_mode", 32'h1, {31'h0, pm});
    wr(OFF_CONTROL, 32'h0, 1'b0);
    cmp("ext_reset", 32'h1, {31'h0, ext});
    wr(OFF_CONFIG, 32'h1fff, 1'b0);
    rd(OFF_CONFIG, 32'h3fff);
    prog_u.set_mode(1'b0, 1'b0);
    // Zeros written to the unimplemented positions must still read as ones
    wr(OFF_CONFIG, 32'h0b9f, 1'b0);
    cmp("cfg_word", 32'h1fff, {18'h0, cfg});
    cmp("lv_enable", 32'h0, {31'h0, lv_en});
    cmp("ext_reset", 32'h0, {31'h0, ext});
    prog_u.set_mode(1'b0, 1'b1);
    cmp("prog_mode", 32'h0, {31'h0, pm});
    prog_u.set_mode(1'b1, 1'b1);
    cmp("prog_mode", 32'h1, {31'h0, pm});
    stop_test();
  end
endmodule
